// ===== rtl/error_path_pkg.sv
package error_path_pkg;

  // Bit rate derived from the reference clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIT_PERIOD_NS = 200;
  localparam int BIT_DIV_CYCLES = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] BIT_DIV_LAST = 3'(BIT_DIV_CYCLES - 1);

  // Word and frame geometry
  localparam int WORD_BITS = 16;
  localparam int FRAME_BITS = 48;
  localparam int FIELD_COUNT = 3;
  localparam int SAT_BITS = 6;
  localparam int DAC_BITS = 10;

  // Field order inside the 48-bit frame
  localparam logic [1:0] FIELD_RANGE = 2'h0;
  localparam logic [1:0] FIELD_AZIMUTH = 2'h1;
  localparam logic [1:0] FIELD_ELEVATION = 2'h2;

  // Arithmetic control counter codes (five bits: sixteen bit steps, then idle)
  localparam logic [4:0] ARITH_FIRST = 5'h00;
  localparam logic [4:0] ARITH_LAST = 5'h0F;
  localparam logic [4:0] ARITH_IDLE = 5'h10;

  // Controller register map (byte addresses) and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DATA_LO = 4'h8;
  localparam logic [3:0] REG_DATA_HI = 4'hC;
  localparam int CTRL_READ_BIT = 0;
  localparam int STATUS_READY_BIT = 0;
  localparam int STATUS_OVERRUN_BIT = 1;
  localparam int STATUS_GATE_BIT = 2;
  localparam logic [31:0] RESET_WORD32 = 32'h0000_0000;
  localparam logic [47:0] RESET_FRAME = 48'h0000_0000_0000;

endpackage

// ===== rtl/teletype_link_if.sv
`timescale 1ns/1ps
interface teletype_link_if;
  logic read_cmd;
  logic [47:0] out_word;
  logic word_shifted_gate;

  modport device (
    input read_cmd,
    output out_word,
    output word_shifted_gate
  );

  modport host (
    output read_cmd,
    input out_word,
    input word_shifted_gate
  );
endinterface

// ===== rtl/serial_error_subtractor.sv
`timescale 1ns/1ps
module serial_error_subtractor
  import error_path_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic teletype_sel_i,
  input wire logic drum_bit_i,
  input wire logic input_bit_i,
  output logic bit_take_o,
  output logic [1:0] field_o,
  output logic [3:0] bit_index_o,
  output logic [DAC_BITS-1:0] range_dac_o,
  output logic [DAC_BITS-1:0] azimuth_dac_o,
  output logic [DAC_BITS-1:0] elevation_dac_o,
  output logic [FIELD_COUNT-1:0] dac_sign_o,
  teletype_link_if.device link
);

  typedef struct packed {
    logic [2:0] div;
    logic [4:0] arith;
    logic [1:0] field;
    logic carry;
    logic [FRAME_BITS-2:0] sr;
    logic [FRAME_BITS-1:0] word;
    logic [FIELD_COUNT-1:0] sign;
    logic gate;
    logic pend;
    logic take;
    logic [FIELD_COUNT*DAC_BITS-1:0] dac;
    logic [FIELD_COUNT-1:0] dsign;
    logic sel_meta;
    logic sel_sync;
  } dev_state_t;

  dev_state_t s_q;
  dev_state_t s_d;

  logic bit_en;
  logic op_a;
  logic op_b;
  logic sum;
  logic carry_out;
  logic read_req;
  logic [FRAME_BITS-1:0] frame_next;
  logic [FIELD_COUNT-1:0] sign_next;
  logic [FIELD_COUNT*DAC_BITS-1:0] dac_next;
  logic [FIELD_COUNT-1:0] dsign_next;

  // Serial adder; the input operand is taken inverted at the adder
  assign op_a = drum_bit_i;
  assign op_b = ~input_bit_i;
  assign sum = op_a ^ op_b ^ s_q.carry;
  assign carry_out = (op_a & op_b) | (op_a & s_q.carry) | (op_b & s_q.carry);

  // Internal mode runs frames back to back; teletype mode waits for a command
  assign read_req = s_q.sel_sync ? link.read_cmd : 1'b1;

  // Frame as it stands when the last adder bit is sampled
  assign frame_next = {sum, s_q.sr};
  // Final carry of the elevation word: one is positive, sign flop gets zero
  assign sign_next = {~carry_out, s_q.sign[1:0]};

  // Per-field saturation, with azimuth shortest path, for the converters
  genvar f;
  generate
    for (f = 0; f < FIELD_COUNT; f++) begin : g_field
      logic [WORD_BITS-1:0] raw;
      logic [WORD_BITS-1:0] mag;
      logic [WORD_BITS-1:0] fixed;
      logic sgn;
      logic out_range;
      logic [WORD_BITS-1:0] sat;
      assign raw = frame_next[f*WORD_BITS +: WORD_BITS];
      // Negative words are ones complement; magnitude seen by inverting
      assign mag = sign_next[f] ? ~raw : raw;
      // Beyond half a turn the azimuth goes the other way round
      assign fixed = (f == FIELD_AZIMUTH && mag[WORD_BITS-1]) ? ~raw : raw;
      assign sgn = (f == FIELD_AZIMUTH && mag[WORD_BITS-1]) ? ~sign_next[f] : sign_next[f];
      // Positive needs top bits all zero, negative all one
      assign out_range = sgn ? ~&fixed[WORD_BITS-1 -: SAT_BITS]
                             : |fixed[WORD_BITS-1 -: SAT_BITS];
      assign sat = out_range ? {WORD_BITS{~sgn}} : fixed;
      // Converter uses low ten bits only; saturation gives full scale
      assign dac_next[f*DAC_BITS +: DAC_BITS] = sat[DAC_BITS-1:0];
      assign dsign_next[f] = sgn;
    end
  endgenerate

  // Next-state logic of the whole serial path
  always_comb begin
    s_d = s_q;
    s_d.take = 1'b0;
    // Source switch is a loose pin; only the second flop is read
    s_d.sel_meta = teletype_sel_i;
    s_d.sel_sync = s_q.sel_meta;
    bit_en = (s_q.div == BIT_DIV_LAST);
    s_d.div = bit_en ? 3'h0 : s_q.div + 3'h1;
    // A command pulse is remembered until the next frame starts
    if (read_req) begin
      s_d.pend = 1'b1;
    end
    if (bit_en) begin
      if (s_q.arith == ARITH_IDLE) begin
        if (s_q.pend) begin
          s_d.arith = ARITH_FIRST;
          s_d.field = FIELD_RANGE;
          s_d.carry = 1'b0;
          s_d.gate = 1'b1;
          s_d.pend = read_req;
        end
      end else begin
        // One operand bit per bit time, least significant first
        s_d.take = 1'b1;
        if (s_q.arith == ARITH_LAST) begin
          // Word-end strobe: sample carry into the sign, start next clean
          s_d.sign[s_q.field] = ~carry_out;
          s_d.carry = 1'b0;
          if (s_q.field == FIELD_ELEVATION) begin
            // 48th bit comes straight from the adder, no shift
            s_d.word = frame_next;
            s_d.gate = 1'b0;
            s_d.arith = ARITH_IDLE;
            s_d.dac = dac_next;
            s_d.dsign = dsign_next;
          end else begin
            s_d.sr = {sum, s_q.sr[FRAME_BITS-2:1]};
            s_d.field = s_q.field + 2'h1;
            s_d.arith = ARITH_FIRST;
          end
        end else begin
          s_d.sr = {sum, s_q.sr[FRAME_BITS-2:1]};
          s_d.carry = carry_out;
          s_d.arith = s_q.arith + 5'h01;
        end
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_q <= '{div: 3'h0, arith: ARITH_IDLE, field: FIELD_RANGE, carry: 1'b0,
               sr: '0, word: RESET_FRAME, sign: '0, gate: 1'b0, pend: 1'b0,
               take: 1'b0, dac: '0, dsign: '0, sel_meta: 1'b1, sel_sync: 1'b1}; // Paced mode: no stray frame
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign bit_take_o = s_q.take;
  assign field_o = s_q.field;
  assign bit_index_o = s_q.arith[3:0];
  assign range_dac_o = s_q.dac[0 +: DAC_BITS];
  assign azimuth_dac_o = s_q.dac[DAC_BITS +: DAC_BITS];
  assign elevation_dac_o = s_q.dac[2*DAC_BITS +: DAC_BITS];
  assign dac_sign_o = s_q.dsign;
  assign link.out_word = s_q.word;
  assign link.word_shifted_gate = s_q.gate;

endmodule // serial_error_subtractor

// ===== rtl/teletype_sampler.sv
`timescale 1ns/1ps
module teletype_sampler
  import error_path_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  teletype_link_if.host link
);

  typedef struct packed {
    logic wait_hi;
    logic [31:0] rdata;
    logic cmd;
    logic gate_prev;
    logic ready;
    logic overrun;
    logic [FRAME_BITS-1:0] word;
  } host_state_t;

  host_state_t s_q;
  host_state_t s_d;

  logic req;
  logic done;
  logic gate_fall;

  assign req = avs_read_i | avs_write_i;
  // Access completes on the edge where the master sees waitrequest low
  assign done = req & ~s_q.wait_hi;
  // Sample only after the gate has fallen
  assign gate_fall = s_q.gate_prev & ~link.word_shifted_gate;

  // Bus slave, command pulse and parallel capture
  always_comb begin
    s_d = s_q;
    s_d.cmd = 1'b0;
    s_d.gate_prev = link.word_shifted_gate;
    // One wait cycle gives time to register read data
    s_d.wait_hi = ~(req & s_q.wait_hi);
    if (req & s_q.wait_hi) begin
      unique case (avs_address_i)
        REG_CTRL: s_d.rdata = RESET_WORD32;
        REG_STATUS: s_d.rdata = {29'h0000_0000, link.word_shifted_gate, s_q.overrun, s_q.ready};
        REG_DATA_LO: s_d.rdata = s_q.word[31:0];
        REG_DATA_HI: s_d.rdata = {16'h0000, s_q.word[FRAME_BITS-1:32]};
        default: s_d.rdata = RESET_WORD32;
      endcase
    end
    if (done & avs_write_i) begin
      if (avs_address_i == REG_CTRL) begin
        s_d.cmd = avs_writedata_i[CTRL_READ_BIT];
      end
      if (avs_address_i == REG_STATUS) begin
        if (avs_writedata_i[STATUS_READY_BIT]) begin
          s_d.ready = 1'b0;
        end
        if (avs_writedata_i[STATUS_OVERRUN_BIT]) begin
          s_d.overrun = 1'b0;
        end
      end
    end
    // Capture wins over a clear in the same cycle
    if (gate_fall) begin
      s_d.word = link.out_word;
      s_d.ready = 1'b1;
      s_d.overrun = s_q.ready | s_q.overrun;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_q <= '{wait_hi: 1'b1, rdata: RESET_WORD32, cmd: 1'b0, gate_prev: 1'b0,
               ready: 1'b0, overrun: 1'b0, word: RESET_FRAME};
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.wait_hi;
  assign link.read_cmd = s_q.cmd;

endmodule // teletype_sampler

// ===== bench/teletype_link_properties.sv
`timescale 1ns/1ps
module teletype_link_properties (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic read_cmd,
  input wire logic [47:0] out_word,
  input wire logic word_shifted_gate
);
  logic [7:0] gate_len_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // Cycles the gate has stood high, cleared while low
  always_ff @(posedge ref_clk_i) begin
    gate_len_q <= (reset_i || !word_shifted_gate) ? 8'h00 : gate_len_q + 8'h01;
  end

  // A command to an idle link opens a frame within one and a half bit times
  property p_start;
    $rose(read_cmd) && !word_shifted_gate |-> ##[1:6] word_shifted_gate;
  endproperty
  a_start: assert property (p_start) else $error("frame did not start");

  property p_pulse;
    read_cmd |=> !read_cmd;
  endproperty
  a_pulse: assert property (p_pulse) else $error("command longer than one cycle");

  // Whole frame is 48 bit times of 4 clocks
  property p_len;
    $fell(word_shifted_gate) |-> gate_len_q == 8'hC0;
  endproperty
  a_len: assert property (p_len) else $error("frame length wrong");

  property p_max;
    word_shifted_gate |-> gate_len_q < 8'hC0;
  endproperty
  a_max: assert property (p_max) else $error("gate held too long");

  // Captured word only moves when the gate falls
  property p_hold;
    !$fell(word_shifted_gate) |-> $stable(out_word);
  endproperty
  a_hold: assert property (p_hold) else $error("word changed off gate fall");

  // Gate stays low for at least one bit time between frames
  property p_gap;
    $fell(word_shifted_gate) |-> !word_shifted_gate [*4];
  endproperty
  a_gap: assert property (p_gap) else $error("frame restarted too soon");
endmodule // teletype_link_properties

// ===== bench/test_serial_error_subtractor.sv
`timescale 1ns/1ps
module test_serial_error_subtractor;
  import error_path_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic drum_bit_i = 1'b0;
  logic input_bit_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, bit_take_o;
  logic [1:0] field_o;
  logic [3:0] bit_index_o;
  logic [9:0] dac_o [3];
  logic [2:0] dac_sign_o;
  logic [15:0] a_w [3];
  logic [15:0] b_w [3];
  logic teletype_sel = 1'b1;
  logic gate_was = 1'b0;
  int take_count = 0;
  int frame_takes = 0;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;

  teletype_link_if link ();
  serial_error_subtractor serial_error_subtractor_inst (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .teletype_sel_i(teletype_sel), .drum_bit_i(drum_bit_i),
    .input_bit_i(input_bit_i), .bit_take_o(bit_take_o), .field_o(field_o),
    .bit_index_o(bit_index_o), .range_dac_o(dac_o[0]), .azimuth_dac_o(dac_o[1]),
    .elevation_dac_o(dac_o[2]), .dac_sign_o(dac_sign_o), .link(link.device));
  teletype_sampler teletype_sampler_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .link(link.host));
  teletype_link_properties teletype_link_properties_inst (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .read_cmd(link.read_cmd), .out_word(link.out_word),
    .word_shifted_gate(link.word_shifted_gate));

  initial forever #25 ref_clk_i = ~ref_clk_i;

  // Next operand bit follows the field and index the device announces
  always @(posedge ref_clk_i) begin
    drum_bit_i <= a_w[field_o][bit_index_o];
    input_bit_i <= b_w[field_o][bit_index_o];
  end

  // Bit takes per frame, latched as the gate falls
  always @(posedge ref_clk_i) begin
    gate_was <= link.word_shifted_gate;
    if (link.word_shifted_gate === 1'b1 && gate_was !== 1'b1) begin
      take_count <= 0;
    end else if (bit_take_o === 1'b1) begin
      take_count <= take_count + 1;
    end
    if (link.word_shifted_gate !== 1'b1 && gate_was === 1'b1) begin
      frame_takes <= take_count + ((bit_take_o === 1'b1) ? 1 : 0);
    end
  end

  // Hang guard, far above six frames of about 250 cycles
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One bus access; waits for waitrequest low, edge by edge
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= adr;
    avs_writedata_i <= wd;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic cmp_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cmp_dac(input string nm, input logic [10:0] exp, input logic [10:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Sign and converter word; A equal to B lands on negative zero
  function automatic logic [10:0] exp_dac(input logic [15:0] a, b, input bit az);
    logic [15:0] r;
    logic neg;
    r = a + ~b;
    neg = !(a > b);
    if (az && (neg ? !r[15] : r[15])) begin
      r = ~r;
      neg = !neg;
    end
    if (!neg && |r[15:10]) r = 16'hFFFF;
    if (neg && !(&r[15:10])) r = 16'h0000;
    return {neg, r[9:0]};
  endfunction

  // Command a frame, wait for capture, check word and converter outputs
  task automatic run_frame(input logic [15:0] a0, a1, a2, b0, b1, b2);
    logic [31:0] rd;
    logic [47:0] fr;
    a_w = '{a0, a1, a2};
    b_w = '{b0, b1, b2};
    fr = {a2 + ~b2, a1 + ~b1, a0 + ~b0};
    bus(1'b1, REG_CTRL, 32'h0000_0001, rd);
    rd = 32'h0000_0000;
    while (rd[STATUS_READY_BIT] !== 1'b1) begin
      bus(1'b0, REG_STATUS, 32'h0000_0000, rd);
    end
    // Free-running frames may already show the next gate
    cmp_word("status", 32'h0000_0001, teletype_sel ? rd : rd & 32'h0000_0003);
    cmp_word("bit takes", 32'h0000_0030, frame_takes);
    bus(1'b0, REG_DATA_LO, 32'h0000_0000, rd);
    cmp_word("frame low", fr[31:0], rd);
    bus(1'b0, REG_DATA_HI, 32'h0000_0000, rd);
    cmp_word("frame high", {16'h0000, fr[47:32]}, {16'h0000, rd[15:0]});
    for (int f = 0; f < 3; f++) begin
      cmp_dac("dac", exp_dac(a_w[f], b_w[f], f == 1), {dac_sign_o[f], dac_o[f]});
    end
    bus(1'b1, REG_STATUS, 32'h0000_0003, rd);
  endtask

  task automatic sc_reg();
    logic [31:0] rd;
    bus(1'b1, 4'h2, 32'hFFFF_FFFF, rd);
    bus(1'b0, 4'h2, 32'h0000_0000, rd);
    cmp_word("unmapped", 32'h0000_0000, rd);
    bus(1'b0, REG_CTRL, 32'h0000_0000, rd);
    cmp_word("ctrl", 32'h0000_0000, rd);
  endtask

  // Saturated positive, azimuth flipped round, negative in range
  task automatic sc_mixed();
    run_frame(16'hCB5C, 16'h0100, 16'h0005, 16'h6E59, 16'hF000, 16'h0105);
  endtask

  // Small positive one low, small negative azimuth, equal words
  task automatic sc_small();
    run_frame(16'h0210, 16'h0020, 16'h1234, 16'h0010, 16'h0030, 16'h1234);
  endtask

  // All-ones operand hands back the stored words
  task automatic sc_dump();
    run_frame(16'hA5C3, 16'h8001, 16'h7FFE, 16'hFFFF, 16'hFFFF, 16'hFFFF);
  endtask

  // Internal source: frames run unbidden; an unread capture flags overrun
  task automatic sc_free();
    logic [31:0] rd;
    teletype_sel <= 1'b0;
    run_frame(16'h0400, 16'h0001, 16'h8000, 16'h0100, 16'h0002, 16'h7FFF);
    rd = 32'h0000_0000;
    while (rd[STATUS_OVERRUN_BIT] !== 1'b1) begin
      bus(1'b0, REG_STATUS, 32'h0000_0000, rd);
    end
    cmp_word("overrun", 32'h0000_0003, rd & 32'h0000_0003);
  endtask

  initial begin
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    sc_reg();
    sc_mixed();
    sc_small();
    sc_dump();
    sc_free();
    end_sim();
  end
endmodule // test_serial_error_subtractor
